// >>> pkg/host_cmd_pkg.sv
package host_cmd_pkg;

  // ==========================================================
  // Command port image layout
  localparam int TX_LSB = 0;
  localparam int TX_W = 3;
  localparam int RX_LSB = 3;
  localparam int RX_W = 3;
  localparam int RUN_BIT = 6;
  localparam int SAT_BIT = 7;

  // ==========================================================
  // Power-up report values
  localparam logic [7:0] CMD_RESET_IMAGE = 8'hFF;
  localparam logic [7:0] SELFTEST_PASS = 8'h00;
  localparam logic [7:0] IMAGE_CLEAR = 8'h00;
  localparam logic [31:0] MAILBOX_RESET = 32'h0000_0000;
  localparam logic [2:0] MAILBOX_BYTES = 3'h4;

  // ==========================================================
  // Send command / acknowledge codes
  localparam logic [2:0] TX_NOP = 3'h0;
  localparam logic [2:0] TX_RSVD_LO = 3'h1;
  localparam logic [2:0] TX_SENT = 3'h2;
  localparam logic [2:0] TX_SUSPEND = 3'h3;
  localparam logic [2:0] TX_ABORT = 3'h4;
  localparam logic [2:0] TX_RESTART = 3'h5;
  localparam logic [2:0] TX_ERROR = 3'h6;
  localparam logic [2:0] TX_RSVD_HI = 3'h7;

  // ==========================================================
  // Descriptor layout (byte offsets) and send error codes
  localparam logic [3:0] BD_CTRL_OFS = 4'h0;
  localparam logic [3:0] BD_LINK_OFS = 4'h2;
  localparam logic [3:0] BD_COUNT_OFS = 4'h4;
  localparam logic [3:0] BD_ADDR_LO_OFS = 4'h6;
  localparam logic [3:0] BD_ADDR_HI_OFS = 4'h8;
  localparam logic [15:0] ADDR_WORD_RESET = 16'h0000;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_MAX_COLL = 4'h1;
  localparam logic [3:0] ERR_UNDERRUN = 4'h2;
  localparam logic [3:0] ERR_CARRIER = 4'h3;
  localparam logic [3:0] ERR_CTS = 4'h4;
  localparam logic [3:0] ERR_TIMEOUT = 4'h5;

  // ==========================================================
  // State types
  typedef enum logic [1:0] {BOOT_TEST, BOOT_ADDR, BOOT_RUN, BOOT_FAIL} boot_t;
  typedef enum logic [2:0] {
    TX_RUN, TX_SUSP_PEND, TX_SUSPENDED, TX_ABORT_RECLAIM, TX_ABORTED
  } tx_state_t;

endpackage

// >>> hdl/desc_addr_assemble.sv
module desc_addr_assemble
  import host_cmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_word_valid,
  input wire logic [3:0] i_word_offset,
  input wire logic [15:0] i_word,
  output logic [31:0] o_buf_addr
);

  // ==========================================================
  // Buffer address halves, low word at offset 6
  logic [15:0] addr_lo;
  logic [15:0] addr_hi;
  logic [15:0] next_addr_lo;
  logic [15:0] next_addr_hi;

  // Capture the matching descriptor word; other words pass by
  always_comb
  begin
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    if (i_word_valid && (i_word_offset == BD_ADDR_LO_OFS))
    begin
      next_addr_lo = i_word;
    end
    if (i_word_valid && (i_word_offset == BD_ADDR_HI_OFS))
    begin
      next_addr_hi = i_word;
    end
  end

  // Register only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_lo <= ADDR_WORD_RESET;
      addr_hi <= ADDR_WORD_RESET;
    end
    else
    begin
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
    end
  end

  assign o_buf_addr = {addr_hi, addr_lo};

endmodule

// >>> hdl/host_command_register_tx_control.sv
module host_command_register_tx_control
  import host_cmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  output logic o_post_strobe,
  input wire logic i_selftest_done,
  input wire logic [7:0] i_selftest_code,
  input wire logic [31:0] i_mailbox_addr,
  output logic o_config_report_req,
  output logic [31:0] o_config_report_addr,
  input wire logic i_config_report_done,
  input wire logic i_indications_enabled,
  input wire logic i_counter_saturated,
  output logic o_exec_req,
  input wire logic i_exec_done,
  output logic o_rx_cmd_valid,
  output logic [2:0] o_rx_cmd,
  input wire logic i_rx_ack_valid,
  input wire logic [2:0] i_rx_ack_code,
  input wire logic i_tx_pkt_active,
  input wire logic i_tx_pkt_done,
  input wire logic [3:0] i_tx_pkt_err,
  input wire logic i_tx_reclaim_done,
  input wire logic i_list_end_moved,
  output logic o_tx_start_allow,
  output logic o_tx_halt,
  output logic o_tx_reclaim_req,
  output logic o_desc_status_wr,
  output logic o_desc_complete,
  output logic o_desc_ok,
  output logic [3:0] o_desc_err_code,
  input wire logic i_desc_word_valid,
  input wire logic [3:0] i_desc_word_offset,
  input wire logic [15:0] i_desc_word,
  output logic [31:0] o_tx_buf_addr
);

  // ==========================================================
  // State
  boot_t boot, next_boot;
  tx_state_t tx_state, next_tx_state;
  logic [7:0] cmd_port, next_cmd_port;
  logic [7:0] image, next_image;
  logic pending, next_pending;
  logic [2:0] byte_idx, next_byte_idx;
  logic [31:0] mailbox_addr, next_mailbox_addr;
  logic report_seen, next_report_seen;
  logic desc_wr, next_desc_wr;
  logic desc_ok, next_desc_ok;
  logic [3:0] desc_err, next_desc_err;
  logic exec_req, next_exec_req;
  logic rx_valid, next_rx_valid;
  logic [2:0] rx_cmd, next_rx_cmd;
  logic post_strobe, next_post_strobe;
  logic host_cmd;
  logic post_now;
  logic [2:0] wr_tx;
  logic tx_ack_set;
  logic [2:0] tx_ack_code;
  logic [7:0] addr_byte_sel;

  assign host_cmd = (boot == BOOT_RUN) && i_host_wr;
  assign wr_tx = i_host_wdata[TX_LSB +: TX_W];
  assign post_now = pending && i_indications_enabled && (boot == BOOT_RUN);
  assign addr_byte_sel = mailbox_addr[{byte_idx[1:0], 3'h0} +: 8];

  // ==========================================================
  // Send state machine; reserved and no-op codes match no branch and leave the state as it is
  always_comb
  begin
    next_tx_state = tx_state;
    tx_ack_set = 1'b0;
    tx_ack_code = TX_NOP;
    if (desc_wr)
    begin
      tx_ack_set = 1'b1;
      tx_ack_code = desc_ok ? TX_SENT : TX_ERROR;
    end
    case (tx_state)
      TX_RUN:
      begin
        if (host_cmd && (wr_tx == TX_SUSPEND))
        begin
          if (i_tx_pkt_active)
          begin
            next_tx_state = TX_SUSP_PEND;
          end
          else
          begin
            next_tx_state = TX_SUSPENDED;
            tx_ack_set = 1'b1;
            tx_ack_code = TX_SUSPEND;
          end
        end
        else if (host_cmd && (wr_tx == TX_ABORT))
        begin
          next_tx_state = TX_ABORT_RECLAIM;
        end
      end
      TX_SUSP_PEND:
      begin
        // Wait until the in-flight packet has also been acknowledged
        if (host_cmd && (wr_tx == TX_ABORT))
        begin
          next_tx_state = TX_ABORT_RECLAIM;
        end
        else if (!i_tx_pkt_active && !i_tx_pkt_done && !desc_wr)
        begin
          next_tx_state = TX_SUSPENDED;
          tx_ack_set = 1'b1;
          tx_ack_code = TX_SUSPEND;
        end
      end
      TX_SUSPENDED:
      begin
        if (host_cmd && (wr_tx == TX_RESTART))
        begin
          next_tx_state = TX_RUN;
        end
        else if (host_cmd && (wr_tx == TX_ABORT))
        begin
          next_tx_state = TX_ABORT_RECLAIM;
        end
      end
      TX_ABORT_RECLAIM:
      begin
        if (i_tx_reclaim_done)
        begin
          next_tx_state = TX_ABORTED;
          tx_ack_set = 1'b1;
          tx_ack_code = TX_ABORT;
        end
      end
      TX_ABORTED:
      begin
        // No way back except the host moving the list end flag
        if (i_list_end_moved)
        begin
          next_tx_state = TX_RUN;
        end
      end
      default:
      begin
        next_tx_state = TX_RUN;
      end
    endcase
  end

  // Transmit side controls follow the state directly
  assign o_tx_start_allow = (boot == BOOT_RUN) && (tx_state == TX_RUN);
  assign o_tx_halt = (tx_state == TX_ABORT_RECLAIM) || (tx_state == TX_ABORTED);
  assign o_tx_reclaim_req = (tx_state == TX_ABORT_RECLAIM);

  // ==========================================================
  // Descriptor status write, then command pulses toward the engines
  always_comb
  begin
    next_desc_wr = i_tx_pkt_done;
    next_desc_ok = desc_ok;
    next_desc_err = desc_err;
    if (i_tx_pkt_done)
    begin
      next_desc_ok = (i_tx_pkt_err == ERR_NONE);
      next_desc_err = i_tx_pkt_err;
    end
    next_exec_req = host_cmd && i_host_wdata[RUN_BIT];
    next_rx_valid = host_cmd;
    next_rx_cmd = host_cmd ? i_host_wdata[RX_LSB +: RX_W] : rx_cmd;
  end

  // ==========================================================
  // Internal image: a read clears it, but a same-cycle event wins
  always_comb
  begin
    next_image = image;
    next_pending = pending;
    if (i_host_rd)
    begin
      next_image = IMAGE_CLEAR;
      next_pending = 1'b0;
    end
    if (post_now)
    begin
      next_pending = 1'b0;
    end
    if (boot == BOOT_RUN)
    begin
      if (tx_ack_set)
      begin
        next_image[TX_LSB +: TX_W] = tx_ack_code;
        next_pending = 1'b1;
      end
      if (i_rx_ack_valid)
      begin
        next_image[RX_LSB +: RX_W] = i_rx_ack_code;
        next_pending = 1'b1;
      end
      if (i_exec_done)
      begin
        next_image[RUN_BIT] = 1'b1;
        next_pending = 1'b1;
      end
      if (i_counter_saturated)
      begin
        next_image[SAT_BIT] = 1'b1;
        next_pending = 1'b1;
      end
    end
  end

  // ==========================================================
  // Power-up report sequence and the visible port
  always_comb
  begin
    next_boot = boot;
    next_cmd_port = cmd_port;
    next_byte_idx = byte_idx;
    next_mailbox_addr = mailbox_addr;
    next_report_seen = report_seen;
    next_post_strobe = 1'b0;
    case (boot)
      BOOT_TEST:
      begin
        next_mailbox_addr = i_mailbox_addr;
        next_report_seen = report_seen || i_config_report_done;
        // Host reads do not gate the result
        if (i_selftest_done && (report_seen || i_config_report_done))
        begin
          next_cmd_port = i_selftest_code;
          next_post_strobe = 1'b1;
          next_byte_idx = 3'h0;
          next_boot = (i_selftest_code == SELFTEST_PASS) ? BOOT_ADDR : BOOT_FAIL;
        end
      end
      BOOT_ADDR:
      begin
        if (i_host_rd)
        begin
          if (byte_idx == MAILBOX_BYTES)
          begin
            next_boot = BOOT_RUN;
          end
          else
          begin
            next_cmd_port = addr_byte_sel;
            next_post_strobe = 1'b1;
            next_byte_idx = byte_idx + 3'h1;
          end
        end
      end
      BOOT_RUN:
      begin
        if (post_now)
        begin
          next_cmd_port = image;
          next_post_strobe = 1'b1;
        end
      end
      BOOT_FAIL:
      begin
        // Nonzero result stays visible; the adapter is dead
        next_boot = BOOT_FAIL;
      end
      default:
      begin
        next_boot = BOOT_FAIL;
      end
    endcase
  end

  assign o_config_report_req = (boot == BOOT_TEST) && !report_seen;

  // ==========================================================
  // Register all state
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      boot <= BOOT_TEST;
      tx_state <= TX_RUN;
      cmd_port <= CMD_RESET_IMAGE;
      image <= IMAGE_CLEAR;
      pending <= 1'b0;
      byte_idx <= 3'h0;
      mailbox_addr <= MAILBOX_RESET;
      report_seen <= 1'b0;
      desc_wr <= 1'b0;
      desc_ok <= 1'b0;
      desc_err <= ERR_NONE;
      exec_req <= 1'b0;
      rx_valid <= 1'b0;
      rx_cmd <= 3'h0;
      post_strobe <= 1'b0;
    end
    else
    begin
      boot <= next_boot;
      tx_state <= next_tx_state;
      cmd_port <= next_cmd_port;
      image <= next_image;
      pending <= next_pending;
      byte_idx <= next_byte_idx;
      mailbox_addr <= next_mailbox_addr;
      report_seen <= next_report_seen;
      desc_wr <= next_desc_wr;
      desc_ok <= next_desc_ok;
      desc_err <= next_desc_err;
      exec_req <= next_exec_req;
      rx_valid <= next_rx_valid;
      rx_cmd <= next_rx_cmd;
      post_strobe <= next_post_strobe;
    end
  end

  assign o_host_rdata = cmd_port;
  assign o_post_strobe = post_strobe;
  assign o_config_report_addr = mailbox_addr;
  assign o_desc_status_wr = desc_wr;
  assign o_desc_complete = desc_wr;
  assign o_desc_ok = desc_wr && desc_ok;
  assign o_desc_err_code = desc_err;
  assign o_exec_req = exec_req;
  assign o_rx_cmd_valid = rx_valid;
  assign o_rx_cmd = rx_cmd;

  // ==========================================================
  // Buffer address pickup from descriptor words
  desc_addr_assemble u_addr
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_word_valid(i_desc_word_valid),
    .i_word_offset(i_desc_word_offset),
    .i_word(i_desc_word),
    .o_buf_addr(o_tx_buf_addr)
  );

  // ==========================================================
  // Checks
  property p_reset_image;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_TEST) |-> (o_host_rdata == CMD_RESET_IMAGE);
  endproperty
  a_reset_image: assert property (p_reset_image) else $error("reset image lost");

  property p_pass_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_TEST) && i_selftest_done && report_seen && (i_selftest_code == SELFTEST_PASS)
      |=> (o_host_rdata == SELFTEST_PASS) && (boot == BOOT_ADDR);
  endproperty
  a_pass_zero: assert property (p_pass_zero) else $error("pass code not shown");

  property p_no_wait;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_TEST) && i_selftest_done && report_seen && !i_host_rd
      |=> (o_host_rdata == $past(i_selftest_code));
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("result waited for read");

  property p_addr_bytes;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_ADDR) && i_host_rd && (byte_idx != MAILBOX_BYTES)
      |=> (o_host_rdata == $past(addr_byte_sel));
  endproperty
  a_addr_bytes: assert property (p_addr_bytes) else $error("mailbox byte wrong");

  property p_withhold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_RUN) && !i_indications_enabled |=> $stable(o_host_rdata);
  endproperty
  a_withhold: assert property (p_withhold) else $error("posted while disabled");

  property p_sat_bit;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_RUN) && i_counter_saturated |=> image[SAT_BIT];
  endproperty
  a_sat_bit: assert property (p_sat_bit) else $error("saturation bit lost");

  property p_sent_ack;
    @(posedge i_clk) disable iff (!i_rst_n)
    (boot == BOOT_RUN) && (tx_state == TX_RUN) && i_tx_pkt_done && !host_cmd
      ##1 !host_cmd |=> (image[TX_LSB +: TX_W] == $past(desc_ok ? TX_SENT : TX_ERROR));
  endproperty
  a_sent_ack: assert property (p_sent_ack) else $error("packet ack wrong");

  property p_abort_ack;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(tx_state == TX_ABORTED) |-> $past(i_tx_reclaim_done) && o_tx_halt;
  endproperty
  a_abort_ack: assert property (p_abort_ack) else $error("abort ack early");

  property p_restart_ignored;
    @(posedge i_clk) disable iff (!i_rst_n)
    host_cmd && ((wr_tx == TX_RESTART) || (wr_tx == TX_NOP) || (wr_tx == TX_RSVD_LO)
      || (wr_tx == TX_RSVD_HI)) && (tx_state == TX_RUN) |=> (tx_state == TX_RUN);
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("state moved");

  property p_success;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_desc_ok |-> o_desc_status_wr && (o_desc_err_code == ERR_NONE);
  endproperty
  a_success: assert property (p_success) else $error("success with error");

  c_run: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(boot == BOOT_RUN));
  c_susp: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    (tx_state == TX_SUSP_PEND) ##[1:50] (tx_state == TX_SUSPENDED));
  c_abort: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(tx_state == TX_ABORTED));
  c_err: cover property (@(posedge i_clk) disable iff (!i_rst_n) desc_wr && !desc_ok);

endmodule

// >>> tb/host_model.sv
module host_model
  import host_cmd_pkg::*;
#(
  parameter int TIMEOUT_CYC = 50
)
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  output logic o_failed
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Host side of the command port
  // Idle levels from time zero so the port never sees an unknown strobe
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
    o_failed = 1'b0;
  end

  // Value is taken for the edge that sees the read strobe
  task automatic read_port(output logic [7:0] d);
    @(posedge i_clk);
    #2;
    d = i_rdata;
    o_rd = 1'b1;
    @(posedge i_clk);
    #2;
    o_rd = 1'b0;
  endtask

  // Caller has cleared the send mailbox status word beforehand
  task automatic write_cmd(input logic [7:0] c);
    @(posedge i_clk);
    #2;
    o_wdata = c;
    o_wr = 1'b1;
    @(posedge i_clk);
    #2;
    o_wr = 1'b0;
  endtask

  // Waits out the all-ones report; the one-second limit is shortened to a cycle count
  task automatic boot(output logic [7:0] res);
    int n;
    n = 0;
    while (i_rdata === CMD_RESET_IMAGE && n < TIMEOUT_CYC)
    begin
      @(posedge i_clk);
      #2;
      n++;
    end
    res = i_rdata;
    o_failed = (res !== SELFTEST_PASS);
  endtask
endmodule

// >>> tb/testbench.sv
module testbench
  import host_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_n, wr, rd, st_done, rep_done, ind_en, sat, ex_done, rxa_v, failed;
  logic post, rep_req, ex_req, rxc_v, act, pdone, rec_done, le_moved, allow, halt, rec_req;
  logic dsw, dc, dok, dwv;
  logic [7:0] wdata, rdata, st_code, d;
  logic [31:0] mbox, rep_addr, buf_addr;
  logic [2:0] rxa, rx_cmd;
  logic [3:0] perr, derr, dofs;
  logic [15:0] dword;
  int fail_count, samples_checked;

  // ==========================================================
  // Clock and instances
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  host_command_register_tx_control host_command_register_tx_control_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_host_wr(wr), .i_host_rd(rd), .i_host_wdata(wdata),
    .o_host_rdata(rdata), .o_post_strobe(post), .i_selftest_done(st_done),
    .i_selftest_code(st_code), .i_mailbox_addr(mbox), .o_config_report_req(rep_req),
    .o_config_report_addr(rep_addr), .i_config_report_done(rep_done),
    .i_indications_enabled(ind_en), .i_counter_saturated(sat), .o_exec_req(ex_req),
    .i_exec_done(ex_done), .o_rx_cmd_valid(rxc_v), .o_rx_cmd(rx_cmd), .i_rx_ack_valid(rxa_v),
    .i_rx_ack_code(rxa), .i_tx_pkt_active(act), .i_tx_pkt_done(pdone), .i_tx_pkt_err(perr),
    .i_tx_reclaim_done(rec_done), .i_list_end_moved(le_moved), .o_tx_start_allow(allow),
    .o_tx_halt(halt), .o_tx_reclaim_req(rec_req), .o_desc_status_wr(dsw),
    .o_desc_complete(dc), .o_desc_ok(dok), .o_desc_err_code(derr),
    .i_desc_word_valid(dwv), .i_desc_word_offset(dofs), .i_desc_word(dword),
    .o_tx_buf_addr(buf_addr));

  host_model host_model_inst (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .o_failed(failed));

  // ==========================================================
  // Shared helpers
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // Bounded wait for the port to take a new value
  task automatic wait_post(output logic [7:0] v);
    int n;
    n = 0;
    while (post !== 1'b1 && n < 30)
    begin
      step();
      n++;
    end
    chk(post, 1'b1, "post strobe");
    v = rdata;
  endtask

  task automatic no_post(int n);
    int k;
    k = 0;
    repeat (n)
    begin
      step();
      if (post === 1'b1) k++;
    end
    chk(k, 0, "unexpected post");
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Boot report, then mailbox bytes; the read that takes the last byte enters normal running
  task automatic t_boot();
    logic [39:0] exp;
    exp = {mbox, SELFTEST_PASS};
    chk(rdata, CMD_RESET_IMAGE, "reset image");
    rst_n = 1'b1;
    step(2);
    chk(rdata, CMD_RESET_IMAGE, "after release");
    chk(rep_req, 1'b1, "report request");
    rep_done = 1'b1;
    step();
    rep_done = 1'b0;
    chk(rep_addr, mbox, "report address");
    st_done = 1'b1;
    step();
    st_done = 1'b0;
    host_model_inst.boot(d);
    chk(d, SELFTEST_PASS, "pass code unread");
    for (int i = 0; i < 5; i++)
    begin
      host_model_inst.read_port(d);
      chk(d, exp[8*i +: 8], "boot byte");
    end
    step();
    chk(allow, 1'b1, "running");
    $display("test boot done");
  endtask

  // Good packet, read clears image, port holds, other field reports with send no-op
  task automatic t_sent();
    pdone = 1'b1;
    perr = ERR_NONE;
    step();
    pdone = 1'b0;
    chk({dsw, dc, dok}, 3'h7, "status write");
    wait_post(d);
    chk(d[2:0], TX_SENT, "sent code");
    host_model_inst.read_port(d);
    step(3);
    chk(rdata[2:0], TX_SENT, "port holds");
    rxa_v = 1'b1;
    rxa = 3'h2;
    step();
    rxa_v = 1'b0;
    wait_post(d);
    chk(d, {2'b00, 3'h2, TX_NOP}, "cleared image");
    host_model_inst.read_port(d);
    $display("test sent done");
  endtask

  // Every send failure reason gives the error code and no success flag
  task automatic t_err();
    for (int e = 1; e < 6; e++)
    begin
      pdone = 1'b1;
      perr = 4'(e);
      step();
      pdone = 1'b0;
      chk(dok, 1'b0, "ok on error");
      chk(derr, 4'(e), "error code");
      wait_post(d);
      chk(d[2:0], TX_ERROR, "error ack");
      host_model_inst.read_port(d);
    end
    $display("test err done");
  endtask

  // Posting held while indications are off; fields merge into one image
  task automatic t_ind();
    ind_en = 1'b0;
    sat = 1'b1;
    ex_done = 1'b1;
    rxa_v = 1'b1;
    rxa = 3'h5;
    step();
    {sat, ex_done, rxa_v} = 3'h0;
    no_post(6);
    ind_en = 1'b1;
    wait_post(d);
    chk(d, {1'b1, 1'b1, 3'h5, TX_NOP}, "merged image");
    // Host would now read and zero every counter
    host_model_inst.read_port(d);
    $display("test ind done");
  endtask

  // Run and receive fields go out; no-op, reserved and idle restart change nothing
  task automatic t_cmd();
    logic [2:0] codes [4];
    codes = '{TX_NOP, TX_RSVD_LO, TX_RSVD_HI, TX_RESTART};
    host_model_inst.write_cmd({1'b0, 1'b1, 3'h6, TX_NOP});
    chk(ex_req, 1'b1, "exec request");
    chk({rxc_v, rx_cmd}, 4'hE, "rx command");
    foreach (codes[i])
    begin
      host_model_inst.write_cmd({5'h00, codes[i]});
      no_post(4);
      chk({allow, halt}, 2'h2, "state kept");
    end
    $display("test cmd done");
  endtask

  // Suspend waits for the packet in flight; restart resumes silently
  task automatic t_susp();
    act = 1'b1;
    host_model_inst.write_cmd({5'h00, TX_SUSPEND});
    chk(allow, 1'b0, "blocked");
    no_post(5);
    act = 1'b0;
    wait_post(d);
    chk(d[2:0], TX_SUSPEND, "suspend ack");
    host_model_inst.read_port(d);
    host_model_inst.write_cmd({5'h00, TX_RESTART});
    chk(allow, 1'b1, "resumed");
    no_post(5);
    host_model_inst.write_cmd({5'h00, TX_SUSPEND});
    wait_post(d);
    chk(d[2:0], TX_SUSPEND, "idle suspend ack");
    host_model_inst.read_port(d);
    host_model_inst.write_cmd({5'h00, TX_RESTART});
    chk(allow, 1'b1, "resumed");
    $display("test susp done");
  endtask

  // Abort: halt at once, ack only after reclaim, leave only on list end move
  task automatic t_abort();
    act = 1'b1;
    host_model_inst.write_cmd({5'h00, TX_ABORT});
    chk({halt, rec_req, allow}, 3'h6, "halt at once");
    act = 1'b0;
    no_post(4);
    rec_done = 1'b1;
    step();
    rec_done = 1'b0;
    chk({halt, rec_req}, 2'h2, "reclaimed");
    wait_post(d);
    chk(d[2:0], TX_ABORT, "abort ack");
    host_model_inst.read_port(d);
    host_model_inst.write_cmd({5'h00, TX_RESTART});
    chk(halt, 1'b1, "no restart");
    le_moved = 1'b1;
    step();
    le_moved = 1'b0;
    chk({halt, allow}, 2'h1, "list end moved");
    // Abort also reaches a transmitter that is already suspended
    host_model_inst.write_cmd({5'h00, TX_SUSPEND});
    wait_post(d);
    chk(d[2:0], TX_SUSPEND, "suspend before abort");
    host_model_inst.read_port(d);
    host_model_inst.write_cmd({5'h00, TX_ABORT});
    chk({halt, rec_req}, 2'h3, "abort while suspended");
    rec_done = 1'b1;
    step();
    rec_done = 1'b0;
    wait_post(d);
    chk(d[2:0], TX_ABORT, "abort ack from suspend");
    host_model_inst.read_port(d);
    le_moved = 1'b1;
    step();
    le_moved = 1'b0;
    chk({halt, allow}, 2'h1, "running again");
    $display("test abort done");
  endtask

  // Buffer address words; the count word must not disturb it
  task automatic t_addr();
    dwv = 1'b1;
    dofs = BD_ADDR_LO_OFS;
    dword = 16'hBEEF;
    step();
    dofs = BD_ADDR_HI_OFS;
    dword = 16'hCAFE;
    step();
    dofs = BD_COUNT_OFS;
    dword = 16'h1234;
    step();
    dwv = 1'b0;
    chk(buf_addr, 32'hCAFE_BEEF, "buffer address");
    $display("test addr done");
  endtask

  // Second reset mid-run, then a failing self-test result that stands
  task automatic t_fail();
    rst_n = 1'b0;
    step(2);
    chk({rdata, allow}, {CMD_RESET_IMAGE, 1'b0}, "mid-run reset");
    rst_n = 1'b1;
    rep_done = 1'b1;
    step();
    rep_done = 1'b0;
    st_done = 1'b1;
    st_code = 8'h5A;
    step();
    st_done = 1'b0;
    host_model_inst.boot(d);
    chk(d, 8'h5A, "fail code");
    chk(failed, 1'b1, "host failure");
    step(3);
    chk({rdata, allow}, {8'h5A, 1'b0}, "fail stands");
    $display("test fail done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {rst_n, st_done, rep_done, sat, ex_done, rxa_v, act, pdone, rec_done, le_moved} = '0;
    {dwv, ind_en} = 2'h1;
    {st_code, rxa, perr, dofs, dword} = '0;
    mbox = 32'h1234_5678;
    fail_count = 0;
    samples_checked = 0;
    step(8);
    t_boot();
    t_sent();
    t_err();
    t_ind();
    t_cmd();
    t_susp();
    t_abort();
    t_addr();
    t_fail();
    test_done();
  end

  // Whole run is under a thousand cycles; this cuts a hang short
  initial
  begin
    #200us;
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done();
  end
endmodule
